// ---- src/pmrs_phy_regs.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - PHY addresses 1 to 4 select ports
// - Registers 0-5, 0x1D, 0x1F implemented only
// - Same registers reachable from SPI, other mapping
// - Control bit 15 soft reset, self-clearing
// - Control bit 14 loops traffic at MAC
// - Control bit 13 forced speed, resets one
// - Control bit 12 enables negotiation, resets one
// - Control bit 11 powers PHY down
// - Control bit 10 isolates PHY from line
// - Control bit 9 restarts negotiation
// - Control bit 8 forced duplex, resets zero
// - Bits 5 to 3 steer crossover behaviour
// - Bits 2 to 0 disable fault, transmit, LEDs
// - Status reports fixed capability bits
// - Status bit 2 shows link up
// - Status bits 5, 4: negotiated, far fault
// - Local_ability_advert writable bits reset one, selector 00001
// - Partner register shows received abilities read-only
// - Cable bit 15 starts test, clears when done
// - Cable result code and near short flag
// - Nine-bit fault distance count in bits 8-0
// - Special register bits 10-8 show port mode
module pmrs_phy_regs #(
    parameter logic [15:0] ID_HIGH = 16'hA5C3, // Arbitrary identity value
    parameter logic [15:0] ID_LOW  = 16'h3C50  // Arbitrary identity value
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // Serial management pins
    input  wire logic                 mdc,
    input  wire logic                 mdio_in,
    output logic                      mdio_out,
    output logic                      mdio_oe,
    // Parallel access from the SPI register decoder
    input  wire logic                 spi_req,
    input  wire logic                 spi_we,
    input  wire logic [4:0]           spi_addr,
    input  wire logic [15:0]          spi_wdata,
    output logic                      spi_ack,
    output logic [15:0]               spi_rdata,
    // Per-port PHY side, index 0 is port 1
    input  pmrs_pkg::pmrs_stat_s      phy_stat [pmrs_pkg::NUM_PORTS],
    output pmrs_pkg::pmrs_cfg_s       phy_cfg  [pmrs_pkg::NUM_PORTS],
    output logic [3:0]                soft_rst_pulse,
    output logic [3:0]                autoneg_rerun_pulse,
    output logic [3:0]                cbl_start_pulse
);
    import pmrs_pkg::*;

    // Read value of one register of one port; unmapped addresses read zero
    function automatic logic [15:0] rd_word(input logic [15:0] ctl,
                                            input logic [15:0] adv,
                                            input logic        run,
                                            input pmrs_stat_s  st,
                                            input logic [4:0]  regad);
        logic [15:0] w;
        w = 16'h0000;
        case (regad)
            REG_CTRL:   w = ctl & CTRL_WR_MASK;
            REG_STATUS: begin
                w = STAT_FIXED;
                w[STAT_LINK_BIT]   = st.link_up;
                w[STAT_ANDONE_BIT] = st.autoneg_done;
                w[STAT_FEF_BIT]    = st.far_fault;
            end
            REG_ID_HI:  w = ID_HIGH;
            REG_ID_LO:  w = ID_LOW;
            REG_ADVERT: w = adv;
            REG_PARTNER: begin
                w = LP_FIXED;
                w[ABIL_PAUSE_BIT]          = st.partner_abil[4];
                w[ABIL_LSB+3:ABIL_LSB]     = st.partner_abil[3:0];
            end
            REG_CABLE: begin
                w[CBL_RUN_BIT]                = run;
                w[CBL_RES_LSB+1:CBL_RES_LSB]  = st.cbl_result;
                w[CBL_SHORT_BIT]              = st.near_short_flag;
                w[8:0]                        = st.cbl_count;
            end
            REG_SPECIAL: w[SPEC_MODE_LSB+2:SPEC_MODE_LSB] = st.op_mode;
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // Parallel slot to register address; the two mappings differ on purpose
    function automatic logic [4:0] slot_to_regad(input logic [2:0] slot);
        if (slot == SLOT_CABLE) begin
            return REG_CABLE;
        end
        if (slot == SLOT_SPECIAL) begin
            return REG_SPECIAL;
        end
        return {2'h0, slot};
    endfunction

    // Synchronisers for the management pins
    logic        mdc_s1_ff;
    logic        mdc_s2_ff;
    logic        mdc_s3_ff;
    logic        mdio_s1_ff;
    logic        mdio_s2_ff;

    // Frame receiver state
    pmrs_state_e state_ff;
    logic [5:0]  ones_ff;
    logic [3:0]  cnt_ff;
    logic [12:0] hdr_ff;
    logic [15:0] shift_ff;
    logic        is_rd_ff;
    logic        is_hit_ff;
    logic [1:0]  md_port_ff;
    logic [4:0]  md_reg_ff;
    logic        mdio_out_ff;
    logic        mdio_oe_ff;

    // Register storage per port
    logic [15:0] ctl_ff [NUM_PORTS];
    logic [15:0] adv_ff [NUM_PORTS];
    logic [3:0]  run_ff;
    logic [3:0]  srst_ff;
    logic [3:0]  rerun_ff;
    logic [3:0]  start_ff;
    logic        spi_ack_ff;
    logic [15:0] spi_rdata_ff;

    // Pin synchronisers; the second stage feeds logic, and the third mdc stage feeds the edge detect
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mdc_s1_ff  <= 1'b0;
            mdc_s2_ff  <= 1'b0;
            mdc_s3_ff  <= 1'b0;
            mdio_s1_ff <= 1'b1;
            mdio_s2_ff <= 1'b1;
        end else begin
            mdc_s1_ff  <= mdc;
            mdc_s2_ff  <= mdc_s1_ff;
            mdc_s3_ff  <= mdc_s2_ff;
            mdio_s1_ff <= mdio_in;
            mdio_s2_ff <= mdio_s1_ff;
        end
    end

    // Edge and header decode; data line is delayed alike so it pairs with the edge
    wire         mdc_rise  = mdc_s2_ff & ~mdc_s3_ff;
    wire         md_bit    = mdio_s2_ff;
    wire  [12:0] nxt_hdr   = {hdr_ff[11:0], md_bit};
    wire  [1:0]  hdr_op    = nxt_hdr[11:10];
    wire  [4:0]  hdr_phy   = nxt_hdr[9:5];
    wire         hdr_valid = nxt_hdr[12] & ((hdr_op == OP_RD) | (hdr_op == OP_WR));
    wire         hdr_hit   = (hdr_phy >= PHYAD_FIRST) & (hdr_phy <= PHYAD_LAST);
    wire  [4:0]  hdr_idx   = hdr_phy - PHYAD_FIRST;
    wire  [15:0] md_rd_word = rd_word(ctl_ff[md_port_ff], adv_ff[md_port_ff],
                                      run_ff[md_port_ff], phy_stat[md_port_ff], md_reg_ff);
    wire         md_last   = mdc_rise & (state_ff == MD_DATA) & (cnt_ff == DATA_LAST);

    // Serial frame walker: preamble, start, header, turnaround, data
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= MD_IDLE;
            ones_ff     <= 6'h00;
            cnt_ff      <= 4'h0;
            hdr_ff      <= 13'h0000;
            shift_ff    <= 16'h0000;
            is_rd_ff    <= 1'b0;
            is_hit_ff   <= 1'b0;
            md_port_ff  <= 2'h0;
            md_reg_ff   <= 5'h00;
            mdio_out_ff <= 1'b0;
            mdio_oe_ff  <= 1'b0;
        end else if (mdc_rise) begin
            case (state_ff)
                MD_IDLE: begin
                    // Preamble suppression is not offered: 32 ones must come first
                    if (md_bit) begin
                        ones_ff <= (ones_ff == PRE_ONES) ? PRE_ONES : ones_ff + 6'h01;
                    end else begin
                        ones_ff <= 6'h00;
                        if (ones_ff == PRE_ONES) begin
                            state_ff <= MD_HDR;
                            cnt_ff   <= 4'h0;
                        end
                    end
                end
                MD_HDR: begin
                    hdr_ff <= nxt_hdr;
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == HDR_LAST) begin
                        cnt_ff     <= 4'h0;
                        state_ff   <= hdr_valid ? MD_TA : MD_IDLE;
                        is_rd_ff   <= (hdr_op == OP_RD);
                        is_hit_ff  <= hdr_hit;
                        md_port_ff <= hdr_idx[1:0];
                        md_reg_ff  <= nxt_hdr[4:0];
                    end
                end
                MD_TA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == 4'h0) begin
                        // Second turnaround bit is driven low by the answering port
                        mdio_out_ff <= 1'b0;
                        mdio_oe_ff  <= is_rd_ff & is_hit_ff;
                    end else begin
                        state_ff    <= MD_DATA;
                        cnt_ff      <= 4'h0;
                        mdio_out_ff <= md_rd_word[15];
                        shift_ff    <= is_rd_ff ? {md_rd_word[14:0], 1'b0} : 16'h0000;
                    end
                end
                MD_DATA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (is_rd_ff) begin
                        mdio_out_ff <= shift_ff[15];
                        shift_ff    <= {shift_ff[14:0], 1'b0};
                    end else begin
                        shift_ff <= {shift_ff[14:0], md_bit};
                    end
                    if (cnt_ff == DATA_LAST) begin
                        state_ff    <= MD_IDLE;
                        mdio_oe_ff  <= 1'b0;
                        mdio_out_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff   <= MD_IDLE;
                    mdio_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    assign mdio_out = mdio_out_ff;
    assign mdio_oe  = mdio_oe_ff;

    // Write source select; serial writes win, the parallel side waits a cycle
    wire         md_wr    = md_last & ~is_rd_ff & is_hit_ff;
    wire  [15:0] md_wdata = {shift_ff[14:0], md_bit};
    wire         spi_take = spi_req & ~spi_ack_ff & ~md_wr;
    wire         wr_en    = md_wr | (spi_take & spi_we);
    wire  [1:0]  wr_port  = md_wr ? md_port_ff : spi_addr[4:3];
    wire  [4:0]  wr_reg   = md_wr ? md_reg_ff : slot_to_regad(spi_addr[2:0]);
    wire  [15:0] wr_data  = md_wr ? md_wdata : spi_wdata;
    wire  [15:0] spi_word = rd_word(ctl_ff[spi_addr[4:3]], adv_ff[spi_addr[4:3]],
                                    run_ff[spi_addr[4:3]], phy_stat[spi_addr[4:3]],
                                    slot_to_regad(spi_addr[2:0]));

    // Parallel answer: one-cycle acknowledge with data held until the next read
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            spi_ack_ff   <= 1'b0;
            spi_rdata_ff <= 16'h0000;
        end else begin
            spi_ack_ff <= spi_take;
            if (spi_take & ~spi_we) begin
                spi_rdata_ff <= spi_word;
            end
        end
    end

    assign spi_ack   = spi_ack_ff;
    assign spi_rdata = spi_rdata_ff;

    // Register writes; only writable bits are stored, so read-only bits stay fixed
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                ctl_ff[p] <= CTRL_RST_VAL;
                adv_ff[p] <= ADV_RST_VAL;
            end
            run_ff   <= 4'h0;
            srst_ff  <= 4'h0;
            rerun_ff <= 4'h0;
            start_ff <= 4'h0;
        end else begin
            srst_ff  <= 4'h0;
            rerun_ff <= 4'h0;
            start_ff <= 4'h0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                // Test completion clears the run bit unless a new start lands now
                if (phy_stat[p].cbl_done) begin
                    run_ff[p] <= 1'b0;
                end
                if (wr_en && (wr_port == p[1:0])) begin
                    case (wr_reg)
                        REG_CTRL: begin
                            if (wr_data[CTRL_SRST_BIT]) begin
                                // Soft reset restores defaults and ignores the rest of the word
                                ctl_ff[p]  <= CTRL_RST_VAL;
                                adv_ff[p]  <= ADV_RST_VAL;
                                srst_ff[p] <= 1'b1;
                            end else begin
                                ctl_ff[p]   <= wr_data & CTRL_WR_MASK;
                                rerun_ff[p] <= wr_data[CTRL_RERUN_BIT];
                            end
                        end
                        REG_ADVERT: begin
                            adv_ff[p] <= (wr_data & ADV_WR_MASK) | LP_FIXED;
                        end
                        REG_CABLE: begin
                            if (wr_data[CBL_RUN_BIT]) begin
                                run_ff[p]   <= 1'b1;
                                start_ff[p] <= 1'b1;
                            end
                        end
                        default: begin
                            // Read-only or unmapped: the write has no effect
                        end
                    endcase
                end
            end
        end
    end

    // Settings to each PHY come straight from stored bits
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            assign phy_cfg[g].loopback = ctl_ff[g][CTRL_LOOP_BIT];
            assign phy_cfg[g].speed_100 = ctl_ff[g][CTRL_SPD_BIT];
            assign phy_cfg[g].autoneg_on = ctl_ff[g][CTRL_AN_BIT];
            assign phy_cfg[g].power_down = ctl_ff[g][CTRL_PD_BIT];
            assign phy_cfg[g].line_detach = ctl_ff[g][CTRL_ISO_BIT];
            assign phy_cfg[g].full_duplex = ctl_ff[g][CTRL_DUP_BIT];
            assign phy_cfg[g].crossover_style_select = ctl_ff[g][CTRL_XSTY_BIT];
            assign phy_cfg[g].straight_pair_force = ctl_ff[g][CTRL_MDI_BIT];
            assign phy_cfg[g].auto_crossover_off = ctl_ff[g][CTRL_XOFF_BIT];
            assign phy_cfg[g].far_fault_off = ctl_ff[g][CTRL_FEF_BIT];
            assign phy_cfg[g].tx_off = ctl_ff[g][CTRL_TXOFF_BIT];
            assign phy_cfg[g].led_off = ctl_ff[g][CTRL_LED_BIT];
            assign phy_cfg[g].cbl_run = run_ff[g];
            assign phy_cfg[g].advert = {adv_ff[g][ABIL_PAUSE_BIT],
                                        adv_ff[g][ABIL_LSB+3:ABIL_LSB]};
        end
    endgenerate

    // Event pulses, one sys_clk cycle each
    assign soft_rst_pulse      = srst_ff;
    assign autoneg_rerun_pulse = rerun_ff;
    assign cbl_start_pulse     = start_ff;

endmodule

// ---- common/pmrs_pkg.sv ----
package pmrs_pkg;

    // Port count and the management addresses that answer
    localparam int          NUM_PORTS   = 4;
    localparam logic [4:0]  PHYAD_FIRST = 5'h01;
    localparam logic [4:0]  PHYAD_LAST  = 5'h04;

    // Register addresses on the serial management interface
    localparam logic [4:0]  REG_CTRL    = 5'h00;
    localparam logic [4:0]  REG_STATUS  = 5'h01;
    localparam logic [4:0]  REG_ID_HI   = 5'h02;
    localparam logic [4:0]  REG_ID_LO   = 5'h03;
    localparam logic [4:0]  REG_ADVERT  = 5'h04;
    localparam logic [4:0]  REG_PARTNER = 5'h05;
    localparam logic [4:0]  REG_CABLE   = 5'h1D;
    localparam logic [4:0]  REG_SPECIAL = 5'h1F;

    // Slots on the parallel side; slots 0 to 5 equal the register address
    localparam logic [2:0]  SLOT_CABLE   = 3'h6;
    localparam logic [2:0]  SLOT_SPECIAL = 3'h7;

    // Reset values, writable masks and fixed read values
    localparam logic [15:0] CTRL_RST_VAL = 16'h3020;
    localparam logic [15:0] CTRL_WR_MASK = 16'h7F3F;
    localparam logic [15:0] STAT_FIXED   = 16'h7808;
    localparam logic [15:0] ADV_RST_VAL  = 16'h05E1;
    localparam logic [15:0] ADV_WR_MASK  = 16'h05E0;
    localparam logic [15:0] LP_FIXED     = 16'h0001;

    // Field positions
    localparam int CTRL_SRST_BIT  = 15;
    localparam int CTRL_LOOP_BIT  = 14;
    localparam int CTRL_SPD_BIT   = 13;
    localparam int CTRL_AN_BIT    = 12;
    localparam int CTRL_PD_BIT    = 11;
    localparam int CTRL_ISO_BIT   = 10;
    localparam int CTRL_RERUN_BIT = 9;
    localparam int CTRL_DUP_BIT   = 8;
    localparam int CTRL_XSTY_BIT  = 5;
    localparam int CTRL_MDI_BIT   = 4;
    localparam int CTRL_XOFF_BIT  = 3;
    localparam int CTRL_FEF_BIT   = 2;
    localparam int CTRL_TXOFF_BIT = 1;
    localparam int CTRL_LED_BIT   = 0;
    localparam int STAT_ANDONE_BIT = 5;
    localparam int STAT_FEF_BIT    = 4;
    localparam int STAT_LINK_BIT   = 2;
    localparam int ABIL_PAUSE_BIT  = 10;
    localparam int ABIL_LSB        = 5;
    localparam int CBL_RUN_BIT     = 15;
    localparam int CBL_RES_LSB     = 13;
    localparam int CBL_SHORT_BIT   = 12;
    localparam int SPEC_MODE_LSB   = 8;

    // Serial frame timing in clock edges of the management clock
    localparam logic [5:0]  PRE_ONES  = 6'h20;
    localparam logic [3:0]  HDR_LAST  = 4'hC;
    localparam logic [3:0]  DATA_LAST = 4'hF;
    localparam logic [1:0]  OP_RD     = 2'h2;
    localparam logic [1:0]  OP_WR     = 2'h1;

    // Frame states, Gray coded along the frame
    typedef enum logic [1:0] {
        MD_IDLE = 2'h0,
        MD_HDR  = 2'h1,
        MD_TA   = 2'h3,
        MD_DATA = 2'h2
    } pmrs_state_e;

    // Live state reported by one port's PHY
    typedef struct packed {
        logic       link_up;
        logic       autoneg_done;
        logic       far_fault;
        logic [4:0] partner_abil;
        logic [2:0] op_mode;
        logic       cbl_done;
        logic [1:0] cbl_result;
        logic       near_short_flag;
        logic [8:0] cbl_count;
    } pmrs_stat_s;

    // Settings driven to one port's PHY
    typedef struct packed {
        logic       loopback;
        logic       speed_100;
        logic       autoneg_on;
        logic       power_down;
        logic       line_detach;
        logic       full_duplex;
        logic       crossover_style_select;
        logic       straight_pair_force;
        logic       auto_crossover_off;
        logic       far_fault_off;
        logic       tx_off;
        logic       led_off;
        logic       cbl_run;
        logic [4:0] advert;
    } pmrs_cfg_s;

endpackage

// ---- bench/pmrs_phy_regs_props.sv ----
`timescale 1ns/100ps
module pmrs_phy_regs_props (
    // Clock and reset
    input wire logic            sys_clk,
    input wire logic            arst_n,
    // Pins and parallel access
    input wire logic            mdio_out,
    input wire logic            mdio_oe,
    input wire logic            spi_req,
    input wire logic            spi_ack,
    // PHY side
    input pmrs_pkg::pmrs_stat_s phy_stat [pmrs_pkg::NUM_PORTS],
    input pmrs_pkg::pmrs_cfg_s  phy_cfg [pmrs_pkg::NUM_PORTS],
    input wire logic [3:0]      soft_rst_pulse,
    input wire logic [3:0]      autoneg_rerun_pulse,
    input wire logic [3:0]      cbl_start_pulse
);
    import pmrs_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    AST_ACK_SINGLE: assert property (spi_ack |=> !spi_ack)
        else $error("ack stood two cycles");
    AST_ACK_BOUND: assert property (spi_req && !spi_ack |-> ##[1:2] spi_ack)
        else $error("request not answered");
    AST_SRST_DEFAULTS: assert property (soft_rst_pulse[0] |-> ##[0:1]
        (phy_cfg[0].speed_100 && phy_cfg[0].autoneg_on && !phy_cfg[0].loopback
         && !phy_cfg[0].power_down && phy_cfg[0].advert == 5'h1F))
        else $error("soft reset left settings");
    AST_RERUN_ONE: assert property (|autoneg_rerun_pulse |=> autoneg_rerun_pulse == 4'h0)
        else $error("restart pulse too long");
    AST_CBL_SET: assert property (cbl_start_pulse[0] |-> ##[0:1] phy_cfg[0].cbl_run)
        else $error("cable run not set");
    AST_CBL_CLEAR: assert property (phy_stat[0].cbl_done ##1 !cbl_start_pulse[0]
        |-> !phy_cfg[0].cbl_run)
        else $error("cable run not cleared");
    AST_TA_ZERO: assert property ($rose(mdio_oe) |-> !mdio_out)
        else $error("turnaround bit not zero");
    AST_OE_LEN: assert property ($rose(mdio_oe) |=> mdio_oe[*8] ##[100:150] !mdio_oe)
        else $error("read drive length wrong");

    // Main scenarios reached
    cover property (|soft_rst_pulse);
    cover property ($rose(mdio_oe));
    cover property (phy_stat[0].cbl_done && phy_cfg[0].cbl_run);
endmodule

bind pmrs_phy_regs pmrs_phy_regs_props u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .spi_req(spi_req), .spi_ack(spi_ack), .phy_stat(phy_stat), .phy_cfg(phy_cfg),
    .soft_rst_pulse(soft_rst_pulse), .autoneg_rerun_pulse(autoneg_rerun_pulse),
    .cbl_start_pulse(cbl_start_pulse));

// ---- bench/pmrs_mdio_host.sv ----
`timescale 1ns/100ps
module pmrs_mdio_host (
    // Clock
    input wire logic    sys_clk,
    // Pin side
    output logic        mdc,
    output logic        mdio_in,
    input wire logic    mdio_out,
    input wire logic    mdio_oe,
    // Read result
    output logic        rd_stb,
    output logic [15:0] rd_word
);
    logic drv_oe;
    logic drv_bit;
    // Pulled-up line: released by both sides it reads one
    assign mdio_in = mdio_oe ? mdio_out : (drv_oe ? drv_bit : 1'b1);
    initial begin
        {mdc, drv_oe, drv_bit, rd_stb, rd_word} = '0;
    end

    // One 400 ns period; sample just before the rise the device answers
    task automatic one_bit(input logic oe, input logic b);
        drv_oe = oe;
        drv_bit = b;
        repeat (4) @(negedge sys_clk);
        rd_word = {rd_word[14:0], mdio_in};
        mdc = 1'b1;
        repeat (4) @(negedge sys_clk);
        mdc = 1'b0;
    endtask

    // Whole frame with its own preamble; read turnaround is released
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd);
        logic [31:0] frm;
        frm = {2'b01, op, pa, ra, 2'b10, wd};
        repeat (32) one_bit(1'b1, 1'b1);
        for (int i = 31; i >= 0; i--) one_bit(op == 2'h1 || i > 17, frm[i]);
        drv_oe = 1'b0;
        rd_stb = (op == 2'h2);
        @(negedge sys_clk);
        rd_stb = 1'b0;
    endtask
endmodule

// ---- bench/test_phy_management_register_set.sv ----
`timescale 1ns/100ps
module test_phy_management_register_set;
    import pmrs_pkg::*;
    localparam logic [15:0] ID_H = 16'h6B2D; // Arbitrary value
    localparam logic [15:0] ID_L = 16'h91E4; // Arbitrary value
    logic        sys_clk, arst_n, mdc, mdio_in, mdio_out, mdio_oe, rd_stb;
    logic        spi_req, spi_we, spi_ack;
    logic [4:0]  spi_addr;
    logic [15:0] spi_wdata, spi_rdata, rd_word, wd;
    logic [3:0]  srst_p, rerun_p, cbl_p, sh_run;
    logic [15:0] sh_ctrl [4], sh_adv [4], exp_q [$], mexp_q [$];
    pmrs_stat_s  phy_stat [NUM_PORTS];
    pmrs_cfg_s   phy_cfg [NUM_PORTS];
    int          err_total, num_checks;

    pmrs_phy_regs #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) u_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .spi_req(spi_req), .spi_we(spi_we),
        .spi_addr(spi_addr), .spi_wdata(spi_wdata), .spi_ack(spi_ack),
        .spi_rdata(spi_rdata), .phy_stat(phy_stat), .phy_cfg(phy_cfg),
        .soft_rst_pulse(srst_p), .autoneg_rerun_pulse(rerun_p), .cbl_start_pulse(cbl_p));
    pmrs_mdio_host u_host (
        .sys_clk(sys_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .rd_stb(rd_stb), .rd_word(rd_word));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Expected read word from shadows and live PHY state
    function automatic logic [15:0] exp_rd(input int p, input logic [2:0] s);
        pmrs_stat_s t;
        t = phy_stat[p];
        case (s)
            3'h0: return sh_ctrl[p];
            3'h1: return 16'h7808 | {10'h0, t.autoneg_done, t.far_fault, 1'b0, t.link_up, 2'h0};
            3'h2: return ID_H;
            3'h3: return ID_L;
            3'h4: return sh_adv[p];
            3'h5: return {5'h0, t.partner_abil[4], 1'b0, t.partner_abil[3:0], 5'h01};
            3'h6: return {sh_run[p], t.cbl_result, t.near_short_flag, 3'h0, t.cbl_count};
            default: return {5'h0, t.op_mode, 8'h00};
        endcase
    endfunction

    // Soft reset ignores the rest of its word; read-only bits keep defaults
    task automatic shadow_wr(input int p, input logic [2:0] s, input logic [15:0] d);
        if (s == 3'h0 && d[15]) begin
            sh_ctrl[p] = CTRL_RST_VAL;
            sh_adv[p] = ADV_RST_VAL;
        end else if (s == 3'h0) sh_ctrl[p] = d & CTRL_WR_MASK;
        else if (s == 3'h4) sh_adv[p] = (d & ADV_WR_MASK) | 16'h0001;
        else if (s == 3'h6 && d[15]) sh_run[p] = 1'b1;
    endtask

    task automatic chk_cfg(input int p);
        check({14'h0, sh_ctrl[p][14:10], sh_ctrl[p][8], sh_ctrl[p][5:0], sh_run[p],
               sh_adv[p][10], sh_adv[p][8:5]}, 32'(phy_cfg[p]));
    endtask

    // Parallel access; we stays put after the ack so the monitor sees it
    task automatic spi(input logic we, input int p, input logic [2:0] s, input logic [15:0] d);
        int n = 0;
        @(negedge sys_clk);
        if (!we) exp_q.push_back(exp_rd(p, s));
        {spi_req, spi_we, spi_addr, spi_wdata} = {1'b1, we, p[1:0], s, d};
        do begin
            @(negedge sys_clk);
            n++;
        end while (spi_ack !== 1'b1 && n < 8);
        spi_req = 1'b0;
        if (we) shadow_wr(p, s, d);
        if (n >= 8) begin
            err_total++;
            report_and_stop();
        end
    endtask

    // Compares each answer with the oldest note
    always @(posedge sys_clk) begin
        if (spi_ack === 1'b1 && spi_we === 1'b0)
            check(exp_q.size() ? exp_q.pop_front() : 16'hXXXX, spi_rdata);
        if (rd_stb === 1'b1)
            check(mexp_q.size() ? mexp_q.pop_front() : 16'hXXXX, rd_word);
    end

    initial begin
        {spi_req, spi_we, spi_addr, spi_wdata, arst_n, sh_run, err_total, num_checks} = '0;
        void'($urandom(50));
        for (int p = 0; p < 4; p++) begin
            phy_stat[p] = pmrs_stat_s'($urandom);
            phy_stat[p].cbl_done = 1'b0;
            sh_ctrl[p] = CTRL_RST_VAL;
            sh_adv[p] = ADV_RST_VAL;
        end
        repeat (16) @(negedge sys_clk);
        arst_n = 1'b1;
        // Every slot of every port after reset, live status random
        for (int p = 0; p < 4; p++) for (int s = 0; s < 8; s++) spi(0, p, s, 16'h0);
        $display("reset read test done");
        // Random writes, one into read-only status, then read back
        for (int p = 0; p < 4; p++) begin
            spi(1, p, 0, (16'($urandom) | 16'h0200) & 16'h7FFF);
            check(1 << p, rerun_p);
            spi(1, p, 4, 16'($urandom));
            spi(1, p, 1, 16'($urandom));
            chk_cfg(p);
            for (int s = 0; s < 5; s++) spi(0, p, s, 16'h0);
        end
        $display("write test done");
        // Soft reset restores defaults; control and advert read back their reset values
        spi(1, 0, 0, 16'h8000 | 16'($urandom));
        check(1, srst_p);
        chk_cfg(0);
        spi(0, 0, 0, 16'h0);
        spi(0, 0, 4, 16'h0);
        // Cable test runs until the PHY reports done
        spi(1, 0, 6, 16'h8000);
        check(1, cbl_p);
        chk_cfg(0);
        spi(0, 0, 6, 16'h0);
        @(negedge sys_clk) phy_stat[0].cbl_done = 1'b1;
        @(negedge sys_clk) phy_stat[0].cbl_done = 1'b0;
        sh_run[0] = 1'b0;
        spi(0, 0, 6, 16'h0);
        chk_cfg(0);
        $display("soft reset and cable test done");
        // Serial frames to all four addresses, then a refused address, an unmapped register, and registers 0x1D and 0x1F
        for (int p = 0; p < 4; p++) begin
            wd = 16'($urandom) & 16'h7FFF;
            u_host.xfer(OP_WR, 5'(p + 1), REG_CTRL, wd);
            repeat (4) @(negedge sys_clk);
            shadow_wr(p, 3'h0, wd);
            chk_cfg(p);
            mexp_q.push_back(sh_ctrl[p]);
            u_host.xfer(OP_RD, 5'(p + 1), REG_CTRL, 16'h0);
        end
        mexp_q.push_back(16'hFFFF);
        u_host.xfer(OP_RD, 5'h00, REG_CTRL, 16'h0);
        mexp_q.push_back(16'h0000);
        u_host.xfer(OP_RD, 5'h01, 5'h06, 16'h0);
        mexp_q.push_back(exp_rd(1, 3'h6));
        u_host.xfer(OP_RD, 5'h02, REG_CABLE, 16'h0);
        mexp_q.push_back(exp_rd(2, 3'h7));
        u_host.xfer(OP_RD, 5'h03, REG_SPECIAL, 16'h0);
        $display("serial test done");
        check(0, exp_q.size() + mexp_q.size());
        report_and_stop();
    end
endmodule
